//--- common/chpbs_defs.svh
// Constants of the coprocessor host port and boot selection block
`ifndef CHPBS_DEFS_SVH
`define CHPBS_DEFS_SVH

// Port register selection on the two address pins
`define CHPBS_SEL_DATA        2'h0
`define CHPBS_SEL_MAILBOX     2'h1
`define CHPBS_SEL_ADDRESS     2'h2
`define CHPBS_SEL_STATUS      2'h3

// Widths and memory size
`define CHPBS_PORT_W          16
`define CHPBS_MEM_AW          13
`define CHPBS_MEM_WORDS       8192
`define CHPBS_GPIO_W          32

// Reset values and pointer step (byte addressed, one word per access)
`define CHPBS_RST_WORD        16'h0000
`define CHPBS_PTR_STEP        16'h0002
`define CHPBS_EXEC_ADDR       16'hff00
`define CHPBS_JUMP_ADDR       16'he000

// Status register field positions
`define CHPBS_ST_OUT_FULL     0
`define CHPBS_ST_IN_FULL      1
`define CHPBS_ST_IN_PENDING   2
`define CHPBS_ST_BOOT_DONE    3
`define CHPBS_ST_MODE_LO      4
`define CHPBS_ST_MODE_HI      5

// Pins touched by test mode and standalone mode
`define CHPBS_TEST_OE_MASK    32'h01f8ff00
`define CHPBS_ALONE_OE_MASK   32'hd0000000
`define CHPBS_OTG_ID_BIT      29

// Timing
`define CHPBS_CLK_MHZ         100
`define CHPBS_BOOT_TIME_US    3000
`define CHPBS_EXEC_DELAY_US   200000
`define CHPBS_BOOT_CYCLES     (`CHPBS_BOOT_TIME_US * `CHPBS_CLK_MHZ)
`define CHPBS_EXEC_CYCLES     (`CHPBS_EXEC_DELAY_US * `CHPBS_CLK_MHZ)

`endif

//--- common/chpbs_pkg.sv
// Types of the coprocessor host port and boot selection block
package chpbs_pkg;

    typedef enum logic [1:0] {
        ST_WAIT_EXEC = 2'b00,
        ST_BOOT_RUN  = 2'b01,
        ST_RUN       = 2'b10
    } chpbs_state_e;

    typedef enum logic [1:0] {
        BOOT_HOST_PORT   = 2'b00,
        BOOT_FAST_SERIAL = 2'b01,
        BOOT_SPI_SLAVE   = 2'b10,
        BOOT_STANDALONE  = 2'b11
    } chpbs_boot_e;

    typedef struct packed {
        chpbs_state_e       state;
        logic [31:0]        cnt;
        logic               captured;
        chpbs_boot_e        boot_mode;
        logic [15:0]        ptr;
        logic [15:0]        mbox_out;
        logic               irq;
        logic               rd_prev;
        logic               wr_prev;
        logic               cs_prev;
        logic [15:0]        wdata;
        logic [15:0]        rdata;
        logic [15:0]        exec_addr;
        logic               exec_pulse;
        logic [31:0]        gpio_oe;
        logic [1:0][15:0]   buf_data;
        logic [1:0]         buf_cnt;
        logic               buf_head;
    } chpbs_state_s;

endpackage

//--- logic/chpbs_host_port.sv
// Parallel host port with mailbox, memory window and boot interface selection
`timescale 1ns/1ps
`include "chpbs_defs.svh"

// Notes on behaviour
// R1 - Address pins 00 data, 01 mailbox, 10 address pointer, 11 status.
// R2 - Strobes and select are active low; access taken at strobe rising edge.
// R3 - Interrupt output shows the outgoing mailbox holds a message for the host.
// R4 - Host data bus is sixteen bits wide and two-way.
// R5 - Pointer advances after every data register access for block transfers.
// R6 - Mailbox carries words both ways between host and internal processor.
// R7 - Data register gives host full memory access without the processor.
// R8 - Status register readable by the host at selection 11.
// R9 - Port keeps up with 16 megabytes per second on its bus.
// R10 - Boot mode is taken from two boot pins at reset release.
// R11 - Boot codes: 00 host port, 01 fast serial, 10 SPI slave, 11 standalone.
// R12 - Boot pins matter only during the 3 ms boot, then free as GPIO.
// R13 - Non-standalone boot enables only the chosen interface and waits for a host.
// R14 - Loading over the interface starts only after reset plus 3 ms boot.
// R15 - Standalone drives boot pins as outputs and enables two debug UART pins.
// R16 - Standalone: pin 29 is OTG identity, 1 peripheral, 0 host.
// R17 - During the first 3 ms of boot two GPIO groups drive as test outputs.
// R18 - Reset restores defaults; execution begins 200 ms later at ff00, jumps e000.
// R19 - Address pointer write sets the memory address for the next data access.
// R20 - Host mailbox write notifies the processor; outgoing mailbox read clears interrupt.
module chpbs_host_port #(
    parameter int unsigned EXEC_CYCLES = `CHPBS_EXEC_CYCLES,
    parameter int unsigned BOOT_CYCLES = `CHPBS_BOOT_CYCLES
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_reset_n,
    // Host side pins
    input  wire logic [1:0]               i_port_addr,
    input  wire logic                     i_read_strobe_n,
    input  wire logic                     i_write_strobe_n,
    input  wire logic                     i_chip_select_n,
    input  wire logic [`CHPBS_PORT_W-1:0] i_data,
    output logic      [`CHPBS_PORT_W-1:0] o_data,
    output logic                          o_data_oe,
    output logic                          o_outgoing_mailbox_irq,
    // Internal processor mailbox side
    input  wire logic                     i_cpu_mbox_out_valid,
    input  wire logic [15:0]              i_cpu_mbox_out_data,
    output logic                          o_cpu_mbox_in_valid,
    output logic      [15:0]              o_cpu_mbox_in_data,
    input  wire logic                     i_cpu_mbox_in_ready,
    output logic                          o_mbox_in_ready,
    // Boot and pin configuration
    input  wire logic [`CHPBS_GPIO_W-1:0] i_gpio,
    output logic      [`CHPBS_GPIO_W-1:0] o_gpio_oe,
    output logic                          o_host_port_enable,
    output logic                          o_fast_serial_enable,
    output logic                          o_spi_slave_enable,
    output logic                          o_standalone,
    output logic                          o_uart_enable,
    output logic                          o_otg_as_peripheral,
    output logic                          o_boot_done,
    output logic                          o_exec_start,
    output logic      [15:0]              o_exec_addr
);

    // Host memory window, one word per even byte address
    logic [15:0] mem [0:`CHPBS_MEM_WORDS-1];

    chpbs_pkg::chpbs_state_s s_reg;
    chpbs_pkg::chpbs_state_s s_next;

    logic        port_enabled;
    logic        rd_done;
    logic        wr_done;
    logic        mem_we;
    logic        buf_push;
    logic        buf_pop;
    logic        out_clear;
    logic [15:0] status_word;
    logic [15:0] mem_rdata;

    // Word index of a byte pointer, shared by reads and writes
    function automatic logic [`CHPBS_MEM_AW-1:0] word_index(input logic [15:0] ptr);
        word_index = ptr[`CHPBS_MEM_AW:1];
    endfunction

    // Selection test on the address pins as they stand in the current cycle, not registered
    function automatic logic sel_is(input logic [1:0] addr, input logic [1:0] code);
        sel_is = (addr == code);
    endfunction

    // Accesses are only honoured once the boot has finished in host port mode
    assign port_enabled = (s_reg.state == chpbs_pkg::ST_RUN) &&
                          (s_reg.boot_mode == chpbs_pkg::BOOT_HOST_PORT); // R13 R14

    // Rising edge of an active low strobe while select was low
    assign rd_done = port_enabled && !s_reg.cs_prev && !s_reg.rd_prev && i_read_strobe_n;  // R2
    assign wr_done = port_enabled && !s_reg.cs_prev && !s_reg.wr_prev && i_write_strobe_n; // R2

    // Read and write side effects, decoded from the address held at the edge; buffer pop by the processor
    assign mem_we    = wr_done && sel_is(i_port_addr, `CHPBS_SEL_DATA);          // R1 R7
    assign buf_push  = wr_done && sel_is(i_port_addr, `CHPBS_SEL_MAILBOX) &&
                       (s_reg.buf_cnt != 2'h2);                                  // R6 R20
    assign out_clear = rd_done && sel_is(i_port_addr, `CHPBS_SEL_MAILBOX);       // R20
    assign buf_pop   = (s_reg.buf_cnt != 2'h0) && i_cpu_mbox_in_ready;

    assign mem_rdata = mem[word_index(s_reg.ptr)];

    // Status word seen by the host
    always_comb begin
        status_word = `CHPBS_RST_WORD;
        status_word[`CHPBS_ST_OUT_FULL]   = s_reg.irq;                           // R8
        status_word[`CHPBS_ST_IN_FULL]    = (s_reg.buf_cnt == 2'h2);
        status_word[`CHPBS_ST_IN_PENDING] = (s_reg.buf_cnt != 2'h0);
        status_word[`CHPBS_ST_BOOT_DONE]  = (s_reg.state == chpbs_pkg::ST_RUN);
        status_word[`CHPBS_ST_MODE_HI:`CHPBS_ST_MODE_LO] = s_reg.boot_mode;
    end

    // Next state of the whole block
    always_comb begin
        s_next            = s_reg;
        s_next.exec_pulse = 1'b0;
        s_next.rd_prev    = i_read_strobe_n;
        s_next.wr_prev    = i_write_strobe_n;
        s_next.cs_prev    = i_chip_select_n;

        // Write data held while the strobe is low, so the edge uses stable data
        if (!i_write_strobe_n && !i_chip_select_n) begin
            s_next.wdata = i_data;                                               // R4
        end

        // Boot sequencing
        case (s_reg.state)
            chpbs_pkg::ST_WAIT_EXEC: begin
                if (!s_reg.captured) begin
                    s_next.captured  = 1'b1;
                    s_next.boot_mode = chpbs_pkg::chpbs_boot_e'(i_gpio[31:30]);  // R10 R11
                end
                if (s_reg.cnt >= EXEC_CYCLES - 1) begin
                    s_next.state      = chpbs_pkg::ST_BOOT_RUN;                  // R18
                    s_next.cnt        = 32'h0000_0000;
                    s_next.exec_pulse = 1'b1;
                    s_next.exec_addr  = `CHPBS_EXEC_ADDR;                        // R18
                    s_next.gpio_oe    = `CHPBS_TEST_OE_MASK;                     // R17
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h0000_0001;
                end
            end
            chpbs_pkg::ST_BOOT_RUN: begin
                // Jump straight from the entry word into the boot code
                s_next.exec_addr = `CHPBS_JUMP_ADDR;                             // R18
                if (s_reg.cnt >= BOOT_CYCLES - 1) begin
                    s_next.state = chpbs_pkg::ST_RUN;                            // R12 R14
                    s_next.cnt   = 32'h0000_0000;
                    if (s_reg.boot_mode == chpbs_pkg::BOOT_STANDALONE) begin
                        s_next.gpio_oe = `CHPBS_ALONE_OE_MASK;                   // R15
                    end else begin
                        s_next.gpio_oe = 32'h0000_0000;                          // R12 R17
                    end
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h0000_0001;
                end
            end
            chpbs_pkg::ST_RUN: begin
                s_next.cnt = s_reg.cnt;
            end
            default: begin
                s_next.state = chpbs_pkg::ST_WAIT_EXEC;
            end
        endcase

        // Pointer load and auto advance; a data access advances by one word
        if (wr_done && sel_is(i_port_addr, `CHPBS_SEL_ADDRESS)) begin
            s_next.ptr = s_reg.wdata;                                            // R19
        end else if ((rd_done || wr_done) && sel_is(i_port_addr, `CHPBS_SEL_DATA)) begin
            s_next.ptr = s_reg.ptr + `CHPBS_PTR_STEP;                            // R5
        end

        // Outgoing mailbox: a processor write in the clearing cycle still wins
        if (i_cpu_mbox_out_valid) begin
            s_next.mbox_out = i_cpu_mbox_out_data;                               // R6
            s_next.irq      = 1'b1;                                              // R3
        end else if (out_clear) begin
            s_next.irq = 1'b0;                                                   // R20
        end

        // Two-entry incoming buffer towards the processor
        if (buf_push) begin
            s_next.buf_data[s_reg.buf_head ^ (s_reg.buf_cnt != 2'h0)] = s_reg.wdata;
        end
        if (buf_pop) begin
            s_next.buf_head = ~s_reg.buf_head;
        end
        case ({buf_push, buf_pop})
            2'b10:   s_next.buf_cnt = s_reg.buf_cnt + 2'h1;
            2'b01:   s_next.buf_cnt = s_reg.buf_cnt - 2'h1;
            default: s_next.buf_cnt = s_reg.buf_cnt;
        endcase

        // Read data prepared every cycle, so it is stable for the whole strobe
        if (sel_is(i_port_addr, `CHPBS_SEL_DATA)) begin
            s_next.rdata = mem_rdata;                                            // R1 R7
        end else if (sel_is(i_port_addr, `CHPBS_SEL_MAILBOX)) begin
            s_next.rdata = s_reg.mbox_out;                                       // R1 R6
        end else if (sel_is(i_port_addr, `CHPBS_SEL_ADDRESS)) begin
            s_next.rdata = s_reg.ptr;                                            // R1
        end else begin
            s_next.rdata = status_word;                                          // R1 R8
        end
    end

    // State register; reset brings every field to its default
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_reg.state      <= chpbs_pkg::ST_WAIT_EXEC;                         // R18
            s_reg.cnt        <= 32'h0000_0000;
            s_reg.captured   <= 1'b0;
            s_reg.boot_mode  <= chpbs_pkg::BOOT_HOST_PORT;
            s_reg.ptr        <= `CHPBS_RST_WORD;
            s_reg.mbox_out   <= `CHPBS_RST_WORD;
            s_reg.irq        <= 1'b0;
            s_reg.rd_prev    <= 1'b1;
            s_reg.wr_prev    <= 1'b1;
            s_reg.cs_prev    <= 1'b1;
            s_reg.wdata      <= `CHPBS_RST_WORD;
            s_reg.rdata      <= `CHPBS_RST_WORD;
            s_reg.exec_addr  <= `CHPBS_RST_WORD;
            s_reg.exec_pulse <= 1'b0;
            s_reg.gpio_oe    <= 32'h0000_0000;
            s_reg.buf_data   <= {2{`CHPBS_RST_WORD}};
            s_reg.buf_cnt    <= 2'h0;
            s_reg.buf_head   <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Memory write port; no reset, contents are undefined at power up
    always_ff @(posedge i_ref_clk) begin
        if (mem_we) begin
            mem[word_index(s_reg.ptr)] <= s_reg.wdata;                           // R7
        end
    end

    // Host bus drive; a three-cycle access fits well inside the 16 MB/s budget
    assign o_data                 = s_reg.rdata;                                 // R4 R9
    assign o_data_oe              = port_enabled && !i_chip_select_n && !i_read_strobe_n; // R2
    assign o_outgoing_mailbox_irq = s_reg.irq;                                   // R3

    // Processor mailbox side
    assign o_cpu_mbox_in_valid = (s_reg.buf_cnt != 2'h0);                        // R20
    assign o_cpu_mbox_in_data  = s_reg.buf_data[s_reg.buf_head];
    assign o_mbox_in_ready     = (s_reg.buf_cnt != 2'h2);

    // Interface enables follow the captured boot mode after the boot window
    assign o_host_port_enable   = port_enabled;                                  // R13
    assign o_fast_serial_enable = (s_reg.state == chpbs_pkg::ST_RUN) &&
                                  (s_reg.boot_mode == chpbs_pkg::BOOT_FAST_SERIAL); // R13
    assign o_spi_slave_enable   = (s_reg.state == chpbs_pkg::ST_RUN) &&
                                  (s_reg.boot_mode == chpbs_pkg::BOOT_SPI_SLAVE); // R13
    assign o_standalone         = (s_reg.state == chpbs_pkg::ST_RUN) &&
                                  (s_reg.boot_mode == chpbs_pkg::BOOT_STANDALONE); // R15
    assign o_uart_enable        = o_standalone;                                  // R15
    // Identity pin is read directly; it means nothing outside standalone mode
    assign o_otg_as_peripheral  = o_standalone && i_gpio[`CHPBS_OTG_ID_BIT];     // R16
    assign o_gpio_oe            = s_reg.gpio_oe;                                 // R15 R17
    assign o_boot_done          = (s_reg.state == chpbs_pkg::ST_RUN);
    assign o_exec_start         = s_reg.exec_pulse;                              // R18
    assign o_exec_addr          = s_reg.exec_addr;

endmodule

//--- tb/chpbs_checker.sv
// Concurrent checks on the host port and boot selection ports
`timescale 1ns/1ps
module chpbs_checker #(
    parameter int unsigned EXEC_CYCLES = 10,
    parameter int unsigned BOOT_CYCLES = 20
) (
    input wire logic        i_ref_clk,
    input wire logic        i_reset_n,
    input wire logic [1:0]  i_port_addr,
    input wire logic        i_read_strobe_n,
    input wire logic        i_chip_select_n,
    input wire logic        i_cpu_mbox_out_valid,
    input wire logic [31:0] i_gpio,
    input wire logic        o_data_oe,
    input wire logic        o_outgoing_mailbox_irq,
    input wire logic        o_cpu_mbox_in_valid,
    input wire logic        o_mbox_in_ready,
    input wire logic [31:0] o_gpio_oe,
    input wire logic        o_host_port_enable,
    input wire logic        o_fast_serial_enable,
    input wire logic        o_spi_slave_enable,
    input wire logic        o_standalone,
    input wire logic        o_uart_enable,
    input wire logic        o_otg_as_peripheral,
    input wire logic        o_boot_done,
    input wire logic        o_exec_start,
    input wire logic [15:0] o_exec_addr
);
    // Cycles since the start pulse, held once the boot window closes; a counter, as the window is long
    logic [31:0] exec_age;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            exec_age <= 32'h0;
        end else if (o_exec_start) begin
            exec_age <= 32'h1;
        end else if (exec_age != 32'h0 && !o_boot_done) begin
            exec_age <= exec_age + 32'h1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    // Read strobe released after a selected low cycle
    sequence rd_take;
        !i_chip_select_n && !i_read_strobe_n ##1 i_read_strobe_n;
    endsequence
    // Start vector, then the jump one cycle later
    sequence exec_seq;
        o_exec_addr == 16'hff00 && o_gpio_oe == 32'h01f8ff00 ##1 o_exec_addr == 16'he000;
    endsequence
    chk_exec_vector: assert property (o_exec_start |-> exec_seq) else $error("bad start vector");
    chk_exec_single: assert property (o_exec_start |=> !o_exec_start [*8]) else $error("start repeats");
    chk_boot_window: assert property ((o_exec_start || exec_age != 32'h0) |->
        o_boot_done == (exec_age >= BOOT_CYCLES)) else $error("boot window length");
    chk_oe_strobe: assert property (o_data_oe |-> !i_chip_select_n && !i_read_strobe_n && o_host_port_enable)
        else $error("bus driven outside read");
    chk_irq_set: assert property (i_cpu_mbox_out_valid |=> o_outgoing_mailbox_irq) else $error("irq not set");
    chk_irq_clear: assert property (rd_take ##0 (i_port_addr == 2'h1 && o_host_port_enable && !i_cpu_mbox_out_valid)
        |=> !o_outgoing_mailbox_irq) else $error("irq not cleared");
    chk_iface_onehot: assert property (o_boot_done |->
        $onehot({o_host_port_enable, o_fast_serial_enable, o_spi_slave_enable, o_standalone}))
        else $error("interface select");
    chk_iface_hold: assert property (o_boot_done && $past(o_boot_done) |->
        $stable({o_host_port_enable, o_fast_serial_enable, o_spi_slave_enable, o_standalone}))
        else $error("mode changed after boot");
    chk_pin_roles: assert property (o_boot_done |-> o_gpio_oe == (o_standalone ? 32'hd0000000 : 32'h0))
        else $error("pin enables");
    chk_otg_role: assert property (o_otg_as_peripheral == (o_standalone && i_gpio[29]) && o_uart_enable == o_standalone)
        else $error("standalone pin roles");
    chk_fifo_full: assert property (!o_mbox_in_ready |-> o_cpu_mbox_in_valid) else $error("full yet empty");
endmodule

bind chpbs_host_port chpbs_checker #(.EXEC_CYCLES(EXEC_CYCLES), .BOOT_CYCLES(BOOT_CYCLES)) u_chpbs_checker (
    .i_ref_clk, .i_reset_n, .i_port_addr, .i_read_strobe_n, .i_chip_select_n, .i_cpu_mbox_out_valid, .i_gpio,
    .o_data_oe, .o_outgoing_mailbox_irq, .o_cpu_mbox_in_valid, .o_mbox_in_ready, .o_gpio_oe, .o_host_port_enable,
    .o_fast_serial_enable, .o_spi_slave_enable, .o_standalone, .o_uart_enable, .o_otg_as_peripheral, .o_boot_done,
    .o_exec_start, .o_exec_addr);

//--- tb/chpbs_host_model.sv
// Behavioural external host processor on the parallel port
`timescale 1ns/1ps
module chpbs_host_model (
    input  wire logic        i_ref_clk,
    input  wire logic [15:0] i_dev_data,
    input  wire logic        i_dev_oe,
    output logic      [1:0]  o_addr,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic             o_cs_n,
    output logic      [15:0] o_bus
);
    logic [15:0] drv_val = 16'h0000;
    logic        drv_en = 1'b0;
    logic [15:0] last = 16'h0000;
    // Released bus shows a changing pattern, never a stale copy
    always_comb o_bus = i_dev_oe ? i_dev_data : (drv_en ? drv_val : ~last);
    always @(posedge i_ref_clk) last <= o_bus;
    // Idle bus: all strobes high
    initial begin
        o_addr = 2'h0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_cs_n = 1'b1;
    end
    // One access, strobe low two cycles so read data settles first
    task automatic access(input logic [1:0] a, input logic wr, input logic [15:0] v, output logic [15:0] r);
        @(negedge i_ref_clk);
        o_addr = a;
        o_cs_n = 1'b0;
        o_rd_n = wr;
        o_wr_n = !wr;
        drv_val = v;
        drv_en = wr;
        repeat (2) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        r = o_bus;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_cs_n = 1'b1;
        // Write data withdrawn off the sampling edge, after the strobe edge was seen
        @(negedge i_ref_clk);
        drv_en = 1'b0;
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the host port and boot selection block
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [1:0] a; logic wr; logic [15:0] v; logic [15:0] exp;} chpbs_tb_row_s;
    logic        i_ref_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        out_valid = 1'b0;
    logic [15:0] out_data = 16'h0000;
    logic        in_take = 1'b0;
    logic [31:0] i_gpio = 32'h0;
    logic [1:0]  port_addr;
    logic        rd_n, wr_n, cs_n, dev_oe, irq, in_valid, in_rdy, host_en, fs_en, spi_en, alone;
    logic        uart_en, otg_per, boot_done, exec_start;
    logic [15:0] bus, dev_data, in_data, exec_addr, rd_val;
    logic [31:0] gpio_oe;
    int          mismatches = 0;
    int          check_count = 0;
    // Pointer is a byte address; each data access steps it by two
    chpbs_tb_row_s rows [11] = '{'{2'h2, 1'b1, 16'h0010, 16'h0}, '{2'h0, 1'b1, 16'ha5c3, 16'h0},
        '{2'h0, 1'b1, 16'h3c5a, 16'h0}, '{2'h2, 1'b0, 16'h0, 16'h0014}, '{2'h2, 1'b1, 16'h0010, 16'h0},
        '{2'h0, 1'b0, 16'h0, 16'ha5c3}, '{2'h0, 1'b0, 16'h0, 16'h3c5a}, '{2'h2, 1'b1, 16'h3ffe, 16'h0},
        '{2'h0, 1'b1, 16'h1234, 16'h0}, '{2'h2, 1'b1, 16'h3ffe, 16'h0}, '{2'h0, 1'b0, 16'h0, 16'h1234}};

    always #5 i_ref_clk = ~i_ref_clk;

    chpbs_host_model u_chpbs_host_model (.i_ref_clk, .i_dev_data(dev_data), .i_dev_oe(dev_oe), .o_addr(port_addr),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n), .o_bus(bus));
    // Short counts keep the boot sequence to a few dozen cycles
    chpbs_host_port #(.EXEC_CYCLES(10), .BOOT_CYCLES(20)) u_chpbs_host_port (.i_ref_clk, .i_reset_n,
        .i_port_addr(port_addr), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_chip_select_n(cs_n),
        .i_data(bus), .o_data(dev_data), .o_data_oe(dev_oe), .o_outgoing_mailbox_irq(irq),
        .i_cpu_mbox_out_valid(out_valid), .i_cpu_mbox_out_data(out_data), .o_cpu_mbox_in_valid(in_valid),
        .o_cpu_mbox_in_data(in_data), .i_cpu_mbox_in_ready(in_take), .o_mbox_in_ready(in_rdy), .i_gpio,
        .o_gpio_oe(gpio_oe), .o_host_port_enable(host_en), .o_fast_serial_enable(fs_en),
        .o_spi_slave_enable(spi_en), .o_standalone(alone), .o_uart_enable(uart_en),
        .o_otg_as_peripheral(otg_per), .o_boot_done(boot_done), .o_exec_start(exec_start), .o_exec_addr(exec_addr));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask
    // Reset with boot pins held, then wait boundedly for run state
    task automatic boot(input logic [1:0] mode);
        int at;
        @(negedge i_ref_clk);
        i_reset_n = 1'b0;
        i_gpio[31:30] = mode;
        repeat (6) @(negedge i_ref_clk);
        check_word({13'h0, boot_done, irq, exec_start, exec_addr}, 32'h0);
        check_word(gpio_oe, 32'h0);
        i_reset_n = 1'b1;
        at = 0;
        for (int n = 1; n < 200 && boot_done !== 1'b1; n++) begin
            @(negedge i_ref_clk);
            if (exec_start === 1'b1) begin
                at = n;
                check_word(exec_addr, 32'h0000ff00);
                check_word(gpio_oe, 32'h01f8ff00);
            end
        end
        check_bit(at >= 10 && at <= 12, 1'b1);
        if (boot_done !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
    endtask

    initial begin
        // Every boot code, pins then changed to show they are free again
        for (int m = 3; m >= 0; m--) begin
            boot(2'(m));
            i_gpio[31:30] = ~2'(m);
            i_gpio[29] = 1'b1;
            @(negedge i_ref_clk);
            check_word({host_en, fs_en, spi_en, alone}, 32'(4'h8 >> m));
            check_bit(otg_per, m == 3);
            check_bit(uart_en, m == 3);
            check_word(gpio_oe, (m == 3) ? 32'hd0000000 : 32'h0);
            if (m != 0) begin
                // Host writes are refused outside host port mode
                u_chpbs_host_model.access(2'h1, 1'b1, 16'h5555, rd_val);
                check_bit(in_valid, 1'b0);
            end
            i_gpio[29] = 1'b0;
            #1 check_bit(otg_per, 1'b0);
        end
        $display("test boot modes done");
        for (int k = 0; k < 11; k++) begin
            u_chpbs_host_model.access(rows[k].a, rows[k].wr, rows[k].v, rd_val);
            if (!rows[k].wr) check_word(rd_val, rows[k].exp);
        end
        u_chpbs_host_model.access(2'h3, 1'b0, 16'h0, rd_val);
        check_word(rd_val, 16'h0008);
        $display("test table done");
        // Three host words into the two-entry buffer while the processor stalls
        for (int k = 0; k < 3; k++) u_chpbs_host_model.access(2'h1, 1'b1, 16'(16'h1100 + k), rd_val);
        check_bit(in_rdy, 1'b0);
        u_chpbs_host_model.access(2'h3, 1'b0, 16'h0, rd_val);
        check_word(rd_val, 16'h000e);
        for (int k = 0; k < 2; k++) begin
            check_bit(in_valid, 1'b1);
            check_word(in_data, 32'h1100 + k);
            in_take = 1'b1;
            @(negedge i_ref_clk);
            in_take = 1'b0;
            @(negedge i_ref_clk);
        end
        check_bit(in_valid, 1'b0);
        $display("test incoming mailbox done");
        out_valid = 1'b1;
        out_data = 16'hbeef;
        @(negedge i_ref_clk);
        out_valid = 1'b0;
        check_bit(irq, 1'b1);
        u_chpbs_host_model.access(2'h3, 1'b0, 16'h0, rd_val);
        check_word(rd_val, 16'h0009);
        u_chpbs_host_model.access(2'h1, 1'b0, 16'h0, rd_val);
        check_word(rd_val, 16'hbeef);
        @(negedge i_ref_clk);
        check_bit(irq, 1'b0);
        $display("test outgoing mailbox done");
        report_and_stop();
    end
endmodule
